//--- common/dsl_pkg.sv
// Shared constants and types for the DDR burst SRAM clocking and latency block.
// Assumes a link domain clocked by the positive input clock and a system clock_in domain.
// Notes on behaviour
// - Strap at ground turns the PLL off
// - PLL off means legacy first-generation DDR timing
// - Strap high: read latency one and half
// - Strap low: read latency exactly one cycle
// - Accesses start only on positive clock rise
// - Outputs timed to output or input clock rises
// - Write words captured on both clock rises
// - Read words launched on both clock rises
// - Controls registered on positive clock rise only
// - Load low: select high reads, low writes
package dsl_pkg;

  localparam int DSL_DATA_W = 18;
  localparam int DSL_ADDR_W = 8;
  localparam int DSL_ADDR_MAX = 16;
  localparam int DSL_LANES = 2;
  localparam int DSL_CLK_MHZ = 250;
  localparam int DSL_LEGACY_MAX_MHZ = 167;
  localparam logic [1:0] DSL_SETTLE_CYC = 2'h3;
  localparam logic DSL_OE_N_RST = 1'b1;
  localparam logic DSL_PLL_OFF_RST = 1'b0;
  localparam logic DSL_SINGLE_RST = 1'b0;

  typedef enum logic {
    DSL_LAT_ONE_HALF,
    DSL_LAT_ONE
  } dsl_lat_type;

  typedef struct packed {
    logic pll_off;
    logic single_clk;
  } dsl_strap_type;

endpackage

//--- logic/dsl_sync.sv
// Two-flop level synchroniser, one bit per lane.
// Assumes each input bit is a level that holds for several destination clocks.
module dsl_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic en_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (en_in) begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign q_out = sync_q;

endmodule // dsl_sync

//--- logic/dsl_array.sv
// Flip-flop storage for the burst SRAM, two-word bursts with byte lanes.
// Assumes writes and reads of the same pair are spaced by the controller.
module dsl_array import dsl_pkg::*; #(
  parameter int DATA_W = DSL_DATA_W,
  parameter int ADDR_W = DSL_ADDR_W,
  parameter int LANES = DSL_LANES
) (
  input wire logic clk_in,
  input wire logic en_in,
  input wire logic we_in,
  input wire logic [ADDR_W-1:0] waddr_in,
  input wire logic [DATA_W-1:0] wdata1_in,
  input wire logic [DATA_W-1:0] wdata2_in,
  input wire logic [LANES-1:0] wbe_in,
  input wire logic [ADDR_W-1:0] raddr_in,
  output logic [DATA_W-1:0] rdata1_out,
  output logic [DATA_W-1:0] rdata2_out
);

  localparam int LANE_W = DATA_W / LANES;
  localparam int DEPTH = 1 << ADDR_W;

  logic [DATA_W-1:0] mem_q [DEPTH];

  // Second word of a burst: low address bit wraps linearly
  function automatic logic [ADDR_W-1:0] burst_mate(input logic [ADDR_W-1:0] a);
    return a ^ ADDR_W'(1);
  endfunction

  // Contents are not reset, as in a real array
  always_ff @(posedge clk_in) begin
    if (en_in && we_in) begin
      for (int i = 0; i < LANES; i++) begin
        if (wbe_in[i]) begin
          mem_q[waddr_in][i*LANE_W +: LANE_W] <= wdata1_in[i*LANE_W +: LANE_W];
          mem_q[burst_mate(waddr_in)][i*LANE_W +: LANE_W] <= wdata2_in[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  assign rdata1_out = mem_q[raddr_in];
  assign rdata2_out = mem_q[burst_mate(raddr_in)];

endmodule // dsl_array

//--- logic/dsl_top.sv
// Clocking, input/output registering and read latency of a DDR burst SRAM.
// Assumes the negative input clock is the exact complement of k_clk_in, so its
// rise is the fall of k_clk_in; output clocks are taken as zero skew to K.
module dsl_top import dsl_pkg::*; #(
  parameter int DATA_W = DSL_DATA_W,
  parameter int ADDR_W = DSL_ADDR_W,
  parameter int LANES = DSL_LANES
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic clk_en_in,
  input wire logic k_clk_in,
  input wire logic pll_disable_n_in,
  input wire logic c_clk_in,
  input wire logic c_n_clk_in,
  input wire logic load_strobe_n_in,
  input wire logic read_write_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [LANES-1:0] byte_write_select_n_in,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_rise_out,
  output logic [DATA_W-1:0] dq_fall_out,
  output logic dq_rise_oe_n_out,
  output logic dq_fall_oe_n_out,
  output dsl_strap_type strap_out
);

  if (DATA_W % LANES != 0 || ADDR_W < 1 || ADDR_W > DSL_ADDR_MAX || LANES < 1) begin : g_bad_cfg
    $error("dsl_top: width, lane or depth setting not supported");
  end

  // System domain: strap sampling
  logic [2:0] pin_sync;
  dsl_strap_type strap_q;
  dsl_strap_type strap_d;
  logic [1:0] settle_q;
  logic [1:0] settle_d;

  dsl_sync #(.W(3)) u_pin_sync (
    .clk_in(clock_in),
    .rst_in(srst_in),
    .en_in(clk_en_in),
    .d_in({pll_disable_n_in, c_clk_in, c_n_clk_in}),
    .q_out(pin_sync)
  );

  always_comb begin
    strap_d = strap_q;
    settle_d = settle_q;
    strap_d.pll_off = !pin_sync[2];
    // Single clock strap is caught once, after the synchroniser has filled
    if (settle_q != DSL_SETTLE_CYC) begin
      settle_d = settle_q + 2'h1;
      if (settle_q == DSL_SETTLE_CYC - 2'h1) begin
        strap_d.single_clk = pin_sync[1] & pin_sync[0];
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      strap_q.pll_off <= DSL_PLL_OFF_RST;
      strap_q.single_clk <= DSL_SINGLE_RST;
      settle_q <= 2'h0;
    end else if (clk_en_in) begin
      strap_q <= strap_d;
      settle_q <= settle_d;
    end
  end

  assign strap_out = strap_q;

  // Link domain: reset, enable and mode arrive as levels
  logic [2:0] k_lvl;
  logic k_rst;
  logic k_ce;
  logic k_pll_off;

  dsl_sync #(.W(3)) u_k_sync (
    .clk_in(k_clk_in),
    .rst_in(1'b0),
    .en_in(1'b1),
    .d_in({srst_in, clk_en_in, strap_q.pll_off}),
    .q_out(k_lvl)
  );

  assign k_rst = k_lvl[2];
  assign k_ce = k_lvl[1];
  assign k_pll_off = k_lvl[0];

  // Rising-edge state
  logic cmd_valid_q;
  logic cmd_valid_d;
  logic cmd_rd_q;
  logic cmd_rd_d;
  logic [ADDR_W-1:0] cmd_addr_q;
  logic [ADDR_W-1:0] cmd_addr_d;
  logic wr_arm_q;
  logic wr_arm_d;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [ADDR_W-1:0] wr_addr_d;
  logic [DATA_W-1:0] wd1_q;
  logic [DATA_W-1:0] wd1_d;
  logic [LANES-1:0] wbe_q;
  logic [LANES-1:0] wbe_d;
  logic rd_live_q;
  logic rd_live_d;
  dsl_lat_type lat_q;
  dsl_lat_type lat_d;
  logic [DATA_W-1:0] rd_w1_q;
  logic [DATA_W-1:0] rd_w1_d;
  logic [DATA_W-1:0] rd_w2_q;
  logic [DATA_W-1:0] rd_w2_d;
  logic [DATA_W-1:0] q_rise_q;
  logic [DATA_W-1:0] q_rise_d;
  logic q_rise_oe_n_q;
  logic q_rise_oe_n_d;
  logic rd_take;
  logic [DATA_W-1:0] rd1;
  logic [DATA_W-1:0] rd2;

  // Falling-edge state (negative input clock rise)
  logic [DATA_W-1:0] wd2_q;
  logic [DATA_W-1:0] wd2_d;
  logic [DATA_W-1:0] q_fall_q;
  logic [DATA_W-1:0] q_fall_d;
  logic q_fall_oe_n_q;
  logic q_fall_oe_n_d;

  // Write-then-read of the same pair one cycle apart reads the old contents
  dsl_array #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .LANES(LANES)) u_array (
    .clk_in(k_clk_in),
    .en_in(k_ce && !k_rst),
    .we_in(wr_arm_q),
    .waddr_in(wr_addr_q),
    .wdata1_in(wd1_q),
    .wdata2_in(wd2_q),
    .wbe_in(wbe_q),
    .raddr_in(cmd_addr_q),
    .rdata1_out(rd1),
    .rdata2_out(rd2)
  );

  always_comb begin
    cmd_valid_d = !load_strobe_n_in;
    cmd_rd_d = read_write_in;
    cmd_addr_d = addr_in;
    wr_arm_d = cmd_valid_q && !cmd_rd_q;
    wr_addr_d = wr_arm_d ? cmd_addr_q : wr_addr_q;
    wd1_d = wr_arm_d ? dq_in : wd1_q;
    wbe_d = wr_arm_d ? ~byte_write_select_n_in : wbe_q;
    rd_take = cmd_valid_q && cmd_rd_q;
    rd_live_d = rd_take;
    lat_d = lat_q;
    rd_w1_d = rd_w1_q;
    rd_w2_d = rd_w2_q;
    if (rd_take) begin
      lat_d = k_pll_off ? DSL_LAT_ONE : DSL_LAT_ONE_HALF;
      rd_w1_d = rd1;
      rd_w2_d = rd2;
    end
    q_rise_d = q_rise_q;
    q_rise_oe_n_d = DSL_OE_N_RST;
    if (rd_take && k_pll_off) begin
      q_rise_d = rd1;
      q_rise_oe_n_d = 1'b0;
    end else if (rd_live_q && lat_q == DSL_LAT_ONE_HALF) begin
      q_rise_d = rd_w2_q;
      q_rise_oe_n_d = 1'b0;
    end
  end

  always_ff @(posedge k_clk_in) begin
    if (k_rst) begin
      cmd_valid_q <= 1'b0;
      cmd_rd_q <= 1'b0;
      cmd_addr_q <= '0;
      wr_arm_q <= 1'b0;
      wr_addr_q <= '0;
      wd1_q <= '0;
      wbe_q <= '0;
      rd_live_q <= 1'b0;
      lat_q <= DSL_LAT_ONE_HALF;
      rd_w1_q <= '0;
      rd_w2_q <= '0;
      q_rise_q <= '0;
      q_rise_oe_n_q <= DSL_OE_N_RST;
    end else if (k_ce) begin
      cmd_valid_q <= cmd_valid_d;
      cmd_rd_q <= cmd_rd_d;
      cmd_addr_q <= cmd_addr_d;
      wr_arm_q <= wr_arm_d;
      wr_addr_q <= wr_addr_d;
      wd1_q <= wd1_d;
      wbe_q <= wbe_d;
      rd_live_q <= rd_live_d;
      lat_q <= lat_d;
      rd_w1_q <= rd_w1_d;
      rd_w2_q <= rd_w2_d;
      q_rise_q <= q_rise_d;
      q_rise_oe_n_q <= q_rise_oe_n_d;
    end
  end

  always_comb begin
    wd2_d = wr_arm_q ? dq_in : wd2_q;
    q_fall_d = q_fall_q;
    q_fall_oe_n_d = DSL_OE_N_RST;
    if (rd_live_q) begin
      // Legacy mode sends the second word here, PLL mode the first
      q_fall_d = (lat_q == DSL_LAT_ONE) ? rd_w2_q : rd_w1_q;
      q_fall_oe_n_d = 1'b0;
    end
  end

  always_ff @(negedge k_clk_in) begin
    if (k_rst) begin
      wd2_q <= '0;
      q_fall_q <= '0;
      q_fall_oe_n_q <= DSL_OE_N_RST;
    end else if (k_ce) begin
      wd2_q <= wd2_d;
      q_fall_q <= q_fall_d;
      q_fall_oe_n_q <= q_fall_oe_n_d;
    end
  end

  assign dq_rise_out = q_rise_q;
  assign dq_fall_out = q_fall_q;
  assign dq_rise_oe_n_out = q_rise_oe_n_q;
  assign dq_fall_oe_n_out = q_fall_oe_n_q;

  sequence s_wr_cmd;
    cmd_valid_q && !cmd_rd_q;
  endsequence

  sequence s_wr_data;
    wr_arm_q && wbe_q == ~$past(byte_write_select_n_in) && wd1_q == $past(dq_in);
  endsequence

  chk_pll_follow: assert property (
    @(posedge clock_in) disable iff (srst_in)
    (clk_en_in && !srst_in) |=> strap_q.pll_off == !$past(pin_sync[2])
  ) else $error("PLL off flag does not follow the strap");

  chk_legacy_latency: assert property (
    @(posedge k_clk_in) disable iff (k_rst || !k_ce)
    (rd_take && k_pll_off) |=> (!q_rise_oe_n_q && q_rise_q == $past(rd1))
  ) else $error("Legacy read word missing one cycle after command");

  chk_pll_latency: assert property (
    @(posedge k_clk_in) disable iff (k_rst || !k_ce)
    (rd_take && !k_pll_off) |=> ##1 (!q_rise_oe_n_q && q_rise_q == $past(rd2, 2))
  ) else $error("PLL mode second read word late or wrong");

  chk_fall_word: assert property (
    @(posedge k_clk_in) disable iff (k_rst || !k_ce)
    rd_live_q |-> (!q_fall_oe_n_q && q_fall_q == ((lat_q == DSL_LAT_ONE) ? rd_w2_q : rd_w1_q))
  ) else $error("Falling-edge read word wrong");

  chk_write_seq: assert property (
    @(posedge k_clk_in) disable iff (k_rst || !k_ce)
    s_wr_cmd |=> s_wr_data
  ) else $error("Write data or byte selects not captured");

  chk_bws_hold: assert property (
    @(posedge k_clk_in) disable iff (k_rst || !k_ce)
    !(cmd_valid_q && !cmd_rd_q) |=> $stable(wbe_q)
  ) else $error("Byte selects changed without a write");

  chk_dual_word: assert property (
    @(negedge k_clk_in) disable iff (k_rst || !k_ce)
    wr_arm_q |=> wd2_q == $past(dq_in)
  ) else $error("Second write word not captured on falling edge");

  chk_read_decode: assert property (
    @(posedge k_clk_in) disable iff (k_rst || !k_ce)
    (!load_strobe_n_in && read_write_in) |=> (rd_take && !wr_arm_d)
  ) else $error("Read command not decoded");

  chk_idle_cycle: assert property (
    @(posedge k_clk_in) disable iff (k_rst || !k_ce)
    load_strobe_n_in |=> ##1 (!rd_live_q && !wr_arm_q)
  ) else $error("Access started without load strobe");

  chk_oe_release: assert property (
    @(posedge k_clk_in) disable iff (k_rst || !k_ce)
    (!(rd_take && k_pll_off) && !(rd_live_q && lat_q == DSL_LAT_ONE_HALF)) |=> q_rise_oe_n_q
  ) else $error("Rising output driven with no read due");

endmodule // dsl_top

//--- verif/dsl_ctrl_model.sv
// Memory controller model: K clock, output clock straps, commands and write data.
// Assumes the device samples commands on K rise and the second write word on K fall.
module dsl_ctrl_model import dsl_pkg::*; (
  output logic k_clk_out,
  output logic c_clk_out,
  output logic c_n_clk_out,
  output logic load_strobe_n_out,
  output logic read_write_out,
  output logic [DSL_ADDR_W-1:0] addr_out,
  output logic [DSL_LANES-1:0] byte_write_select_n_out,
  output logic [DSL_DATA_W-1:0] dq_out
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    c_clk_out = 1'b1;
    c_n_clk_out = 1'b1;
    load_strobe_n_out = 1'b1;
    read_write_out = 1'b0;
    addr_out = '0;
    byte_write_select_n_out = '1;
    dq_out = '0;
    k_clk_out = 1'b0;
    #1.3;
    // 6 ns period stays under the PLL-off ceiling
    forever #3 k_clk_out = ~k_clk_out;
  end

  // One access; signals change only just after K rise
  task automatic op(input logic rd, input logic [DSL_ADDR_W-1:0] a, input logic [DSL_DATA_W-1:0] w1,
                    input logic [DSL_DATA_W-1:0] w2, input logic [DSL_LANES-1:0] be_n);
    @(posedge k_clk_out);
    load_strobe_n_out <= 1'b0;
    read_write_out <= rd;
    addr_out <= a;
    @(posedge k_clk_out);
    load_strobe_n_out <= 1'b1;
    read_write_out <= ~rd;
    addr_out <= ~a;
    if (!rd) begin
      dq_out <= w1;
      byte_write_select_n_out <= be_n;
      @(posedge k_clk_out);
      dq_out <= w2;
      // Selects flip before K fall; only the rise sample may count
      byte_write_select_n_out <= ~be_n;
      @(posedge k_clk_out);
      dq_out <= ~w2;
    end
  endtask
endmodule // dsl_ctrl_model

//--- verif/tb_top.sv
// Self-checking bench for the DDR burst SRAM clocking and latency block.
// Assumes the controller model makes K; clock_in and K are unrelated in phase.
module tb_top;
  import dsl_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic off;
    logic rd;
    logic [7:0] a;
    logic [17:0] w1;
    logic [17:0] w2;
    logic [1:0] be_n;
  } dsl_row_type;

  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic pll_disable_n_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic k_clk, c_clk, c_n_clk, ld_n, rw;
  logic [7:0] addr;
  logic [1:0] bws_n;
  logic [17:0] dq, dq_rise, dq_fall;
  logic oe_r_n, oe_f_n;
  dsl_strap_type strap;
  logic [17:0] mem [0:255];
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;
  dsl_row_type rows [8] = '{
    '{1'b0, 1'b0, 8'h10, 18'h2A5A5, 18'h15A5A, 2'h0},
    '{1'b0, 1'b0, 8'h21, 18'h3FFFF, 18'h00001, 2'h0},
    '{1'b0, 1'b1, 8'h10, 18'h00000, 18'h00000, 2'h3},
    '{1'b0, 1'b1, 8'h21, 18'h00000, 18'h00000, 2'h3},
    '{1'b1, 1'b0, 8'h10, 18'h00000, 18'h3FFFF, 2'h1},
    '{1'b1, 1'b0, 8'h20, 18'h12345, 18'h2BCDE, 2'h2},
    '{1'b1, 1'b1, 8'h11, 18'h00000, 18'h00000, 2'h3},
    '{1'b1, 1'b1, 8'h20, 18'h00000, 18'h00000, 2'h3}};

  dsl_ctrl_model ctrl (.k_clk_out(k_clk), .c_clk_out(c_clk), .c_n_clk_out(c_n_clk), .load_strobe_n_out(ld_n),
    .read_write_out(rw), .addr_out(addr), .byte_write_select_n_out(bws_n), .dq_out(dq));

  dsl_top dut (.clock_in(clock_in), .srst_in(srst_in), .clk_en_in(clk_en_in), .k_clk_in(k_clk),
    .pll_disable_n_in(pll_disable_n_in), .c_clk_in(c_clk), .c_n_clk_in(c_n_clk), .load_strobe_n_in(ld_n),
    .read_write_in(rw), .addr_in(addr), .byte_write_select_n_in(bws_n), .dq_in(dq), .dq_rise_out(dq_rise),
    .dq_fall_out(dq_fall), .dq_rise_oe_n_out(oe_r_n), .dq_fall_oe_n_out(oe_f_n), .strap_out(strap));

  always #2 clock_in = ~clock_in;

  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      results();
    end
  end

  task automatic results();
    if (n_fail == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk_word(input string name, input logic [17:0] exp, input logic [17:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %b seen %b", name, exp, got);
      n_fail++;
    end
  endtask

  task automatic do_read(input logic [7:0] a, input logic off);
    ctrl.op(1'b1, a, 18'h00000, 18'h00000, 2'h3);
    @(posedge k_clk);
    if (off) begin
      #1;
      chk_word("rise_word", mem[a], dq_rise);
      chk_bit("rise_oe_n", 1'b0, oe_r_n);
      @(negedge k_clk);
      #1;
      chk_word("fall_word", mem[a ^ 8'h01], dq_fall);
    end else begin
      @(negedge k_clk);
      #1;
      chk_word("fall_word", mem[a], dq_fall);
      chk_bit("fall_oe_n", 1'b0, oe_f_n);
      @(posedge k_clk);
      #1;
      chk_word("rise_word", mem[a ^ 8'h01], dq_rise);
    end
    repeat (2) @(posedge k_clk);
    #1;
    chk_bit("rise_oe_n", 1'b1, oe_r_n);
    chk_bit("fall_oe_n", 1'b1, oe_f_n);
  endtask

  initial begin
    repeat (6) @(posedge clock_in);
    chk_bit("rise_oe_n", 1'b1, oe_r_n);
    srst_in <= 1'b0;
    repeat (10) @(posedge k_clk);
    chk_bit("strap_single", 1'b1, strap.single_clk);
    chk_bit("strap_pll_off", 1'b0, strap.pll_off);
    foreach (rows[i]) begin
      if (rows[i].off !== !pll_disable_n_in) begin
        @(posedge clock_in);
        pll_disable_n_in <= !rows[i].off;
        repeat (8) @(posedge k_clk);
        chk_bit("strap_pll_off", rows[i].off, strap.pll_off);
      end
      if (rows[i].rd) begin
        do_read(rows[i].a, rows[i].off);
      end else begin
        ctrl.op(1'b0, rows[i].a, rows[i].w1, rows[i].w2, rows[i].be_n);
        // Disabled lanes keep their old contents
        for (int l = 0; l < 2; l++) begin
          if (!rows[i].be_n[l]) begin
            mem[rows[i].a][9*l +: 9] = rows[i].w1[9*l +: 9];
            mem[rows[i].a ^ 8'h01][9*l +: 9] = rows[i].w2[9*l +: 9];
          end
        end
      end
    end
    // Clock enable low: strap and link pipeline both freeze
    @(posedge clock_in);
    clk_en_in <= 1'b0;
    repeat (4) @(posedge k_clk);
    @(posedge clock_in);
    pll_disable_n_in <= !pll_disable_n_in;
    repeat (8) @(posedge k_clk);
    chk_bit("strap_frozen", rows[7].off, strap.pll_off);
    // A read while frozen must not reach the outputs
    ctrl.op(1'b1, 8'h10, 18'h00000, 18'h00000, 2'h3);
    repeat (3) @(posedge k_clk);
    #1;
    chk_bit("rise_oe_n", 1'b1, oe_r_n);
    chk_bit("fall_oe_n", 1'b1, oe_f_n);
    @(posedge clock_in);
    clk_en_in <= 1'b1;
    repeat (4) @(posedge k_clk);
    chk_bit("strap_pll_off", !pll_disable_n_in, strap.pll_off);
    @(posedge clock_in);
    srst_in <= 1'b1;
    repeat (6) @(posedge clock_in);
    chk_bit("rise_oe_n", 1'b1, oe_r_n);
    chk_bit("strap_pll_off", 1'b0, strap.pll_off);
    results();
  end
endmodule // tb_top
